//--- core/tfp_out_unit.sv
module tfp_out_unit
  import tfp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // timing events
  input wire logic tick_i,
  input wire logic fast_i,
  input wire logic phase_i,
  input wire logic count_up_i,
  input wire logic match_i,
  input wire logic wrap_i,
  input wire logic cmp_is_top_i,
  input wire logic cmp_is_floor_i,
  // configuration
  input wire logic [1:0] action_i,
  input wire logic toggle_ok_i,
  input wire logic pin_dir_i,
  // pin
  output logic pin_o,
  output logic pin_oe_o
);
  logic level_ff;
  logic nxt_level_ff;
  logic inv;

  always_comb begin
    inv = action_i[0];
    nxt_level_ff = level_ff;
    if (tick_i) begin
      if (action_i == TFP_ACT_TOGGLE) begin
        if (toggle_ok_i && match_i) begin
          nxt_level_ff = ~level_ff;
        end
      end else if (action_i[1]) begin
        if (fast_i) begin
          // match beats wrap, so compare at limit stays constant
          if (match_i) begin
            nxt_level_ff = ~inv;
          end else if (wrap_i) begin
            nxt_level_ff = inv;
          end
        end else if (phase_i && match_i) begin
          if (cmp_is_top_i) begin
            nxt_level_ff = ~inv;
          end else if (cmp_is_floor_i) begin
            nxt_level_ff = inv;
          end else if (count_up_i) begin
            nxt_level_ff = inv;
          end else begin
            nxt_level_ff = ~inv;
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      level_ff <= 1'b0;
    end else begin
      level_ff <= nxt_level_ff;
    end
  end

  assign pin_o = level_ff;
  // drive only when pin is output
  assign pin_oe_o = pin_dir_i && (action_i != TFP_ACT_OFF);
endmodule // tfp_out_unit

//--- core/tfp_pkg.sv
package tfp_pkg;
  localparam int TFP_CNT_W = 16;
  localparam int TFP_NUM_CH = 2;
  // register byte offsets
  localparam logic [7:0] TFP_OFS_CTRL = 8'h00;
  localparam logic [7:0] TFP_OFS_CMPA = 8'h04;
  localparam logic [7:0] TFP_OFS_CMPB = 8'h08;
  localparam logic [7:0] TFP_OFS_CAPT = 8'h0C;
  localparam logic [7:0] TFP_OFS_CNT = 8'h10;
  localparam logic [7:0] TFP_OFS_FLAGS = 8'h14;
  // control field positions
  localparam int TFP_CTRL_MODE_LSB = 0;
  localparam int TFP_CTRL_ACTB_LSB = 4;
  localparam int TFP_CTRL_ACTA_LSB = 6;
  localparam int TFP_CTRL_DIR_LSB = 8;
  localparam int TFP_CTRL_W = 10;
  // flag bit positions
  localparam int TFP_FLG_OVF = 0;
  localparam int TFP_FLG_CMPA = 1;
  localparam int TFP_FLG_CMPB = 2;
  localparam int TFP_FLG_CAPT = 3;
  localparam int TFP_FLG_W = 4;
  // waveform modes
  localparam logic [3:0] TFP_MODE_PC8 = 4'h1;
  localparam logic [3:0] TFP_MODE_PC9 = 4'h2;
  localparam logic [3:0] TFP_MODE_PC10 = 4'h3;
  localparam logic [3:0] TFP_MODE_FP8 = 4'h5;
  localparam logic [3:0] TFP_MODE_FP9 = 4'h6;
  localparam logic [3:0] TFP_MODE_FP10 = 4'h7;
  localparam logic [3:0] TFP_MODE_PC_CAPT = 4'hA;
  localparam logic [3:0] TFP_MODE_PC_CMPA = 4'hB;
  localparam logic [3:0] TFP_MODE_FP_CAPT = 4'hE;
  localparam logic [3:0] TFP_MODE_FP_CMPA = 4'hF;
  // output actions
  localparam logic [1:0] TFP_ACT_OFF = 2'h0;
  localparam logic [1:0] TFP_ACT_TOGGLE = 2'h1;
  // limits and reset values
  localparam logic [15:0] TFP_TOP8 = 16'h00FF;
  localparam logic [15:0] TFP_TOP9 = 16'h01FF;
  localparam logic [15:0] TFP_TOP10 = 16'h03FF;
  localparam logic [15:0] TFP_CEIL = 16'hFFFF;
  localparam logic [15:0] TFP_FLOOR = 16'h0000;
  localparam logic [15:0] TFP_ONE = 16'h0001;
  localparam logic [15:0] TFP_CNT_RST = 16'h0000;
  localparam logic [TFP_CTRL_W-1:0] TFP_CTRL_RST = 10'h000;
  localparam logic [TFP_FLG_W-1:0] TFP_FLG_RST = 4'h0;
  typedef enum logic {DIR_UP, DIR_DOWN} tfp_dir_t;
endpackage : tfp_pkg

//--- core/tfp_timer16_pwm.sv
module tfp_timer16_pwm
  import tfp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // prescaled tick
  input wire logic timer_tick_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // compare output pins
  output logic compare_a_output_o,
  output logic compare_a_output_oe_o,
  output logic compare_b_output_o,
  output logic compare_b_output_oe_o
);

  function automatic logic is_fast(input logic [3:0] m);
    is_fast = (m == TFP_MODE_FP8) || (m == TFP_MODE_FP9) || (m == TFP_MODE_FP10) ||
              (m == TFP_MODE_FP_CAPT) || (m == TFP_MODE_FP_CMPA);
  endfunction

  function automatic logic is_phase(input logic [3:0] m);
    is_phase = (m == TFP_MODE_PC8) || (m == TFP_MODE_PC9) || (m == TFP_MODE_PC10) ||
               (m == TFP_MODE_PC_CAPT) || (m == TFP_MODE_PC_CMPA);
  endfunction

  // fixed limit for a mode, or ceiling when the limit is a register
  function automatic logic [15:0] fixed_top(input logic [3:0] m);
    if (m == TFP_MODE_FP8 || m == TFP_MODE_PC8) begin
      fixed_top = TFP_TOP8;
    end else if (m == TFP_MODE_FP9 || m == TFP_MODE_PC9) begin
      fixed_top = TFP_TOP9;
    end else if (m == TFP_MODE_FP10 || m == TFP_MODE_PC10) begin
      fixed_top = TFP_TOP10;
    end else begin
      fixed_top = TFP_CEIL;
    end
  endfunction

  function automatic logic capt_is_top(input logic [3:0] m);
    capt_is_top = (m == TFP_MODE_FP_CAPT) || (m == TFP_MODE_PC_CAPT);
  endfunction

  function automatic logic cmpa_is_top(input logic [3:0] m);
    cmpa_is_top = (m == TFP_MODE_FP_CMPA) || (m == TFP_MODE_PC_CMPA);
  endfunction

  // byte lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // bus state
  logic ack_ff;
  logic nxt_ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata_ff;
  // control and value registers
  logic [TFP_CTRL_W-1:0] ctrl_ff;
  logic [TFP_CTRL_W-1:0] nxt_ctrl_ff;
  logic [15:0] capt_ff;
  logic [15:0] nxt_capt_ff;
  logic [15:0] cmp_buf_ff [TFP_NUM_CH];
  logic [15:0] nxt_cmp_buf_ff [TFP_NUM_CH];
  logic [15:0] cmp_act_ff [TFP_NUM_CH];
  logic [15:0] nxt_cmp_act_ff [TFP_NUM_CH];
  // counter state
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt_ff;
  tfp_dir_t dir_ff;
  tfp_dir_t nxt_dir_ff;
  logic [TFP_FLG_W-1:0] flags_ff;
  logic [TFP_FLG_W-1:0] nxt_flags_ff;
  // decoded controls and events
  logic [3:0] mode;
  logic [1:0] act_sel [TFP_NUM_CH];
  logic fast;
  logic phase;
  logic [15:0] top;
  logic at_top;
  logic fast_wrap;
  logic phase_top;
  logic floor_reach;
  logic update;
  logic [TFP_NUM_CH-1:0] match;
  logic wr;
  logic rd;
  logic [31:0] wmerge_ctrl;
  logic [31:0] wmerge_cmp [TFP_NUM_CH];
  logic [31:0] wmerge_capt;
  logic [31:0] wmerge_cnt;
  logic [TFP_NUM_CH-1:0] ch_pin;
  logic [TFP_NUM_CH-1:0] ch_oe;
  logic [TFP_NUM_CH-1:0] cmp_top;
  logic [TFP_NUM_CH-1:0] cmp_floor;

  assign mode = ctrl_ff[TFP_CTRL_MODE_LSB +: 4];
  assign act_sel[0] = ctrl_ff[TFP_CTRL_ACTA_LSB +: 2];
  assign act_sel[1] = ctrl_ff[TFP_CTRL_ACTB_LSB +: 2];
  assign fast = is_fast(mode);
  assign phase = is_phase(mode);

  always_comb begin
    if (capt_is_top(mode)) begin
      top = capt_ff;
    end else if (cmpa_is_top(mode)) begin
      top = cmp_act_ff[0];
    end else begin
      top = fixed_top(mode);
    end
  end

  assign at_top = (cnt_ff == top);
  assign fast_wrap = timer_tick_i && fast && at_top;
  assign phase_top = timer_tick_i && phase && at_top && (dir_ff == DIR_UP);
  assign floor_reach = timer_tick_i && phase && (dir_ff == DIR_DOWN) && (cnt_ff == TFP_ONE);
  assign update = fast_wrap || phase_top;

  generate
    for (genvar c = 0; c < TFP_NUM_CH; c++) begin : g_match
      assign match[c] = timer_tick_i && (fast || phase) && (cnt_ff == cmp_act_ff[c]);
      assign cmp_top[c] = (cmp_act_ff[c] == top);
      assign cmp_floor[c] = (cmp_act_ff[c] == TFP_FLOOR);
    end
  endgenerate

  // bus decode, one wait state then ack
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
  // only reads load the read data, so it holds across writes
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_ff;
  assign wmerge_ctrl = lane_merge({22'h000000, ctrl_ff}, wb_dat_i, wb_sel_i);
  assign wmerge_cmp[0] = lane_merge({16'h0000, cmp_buf_ff[0]}, wb_dat_i, wb_sel_i);
  assign wmerge_cmp[1] = lane_merge({16'h0000, cmp_buf_ff[1]}, wb_dat_i, wb_sel_i);
  assign wmerge_capt = lane_merge({16'h0000, capt_ff}, wb_dat_i, wb_sel_i);
  assign wmerge_cnt = lane_merge({16'h0000, cnt_ff}, wb_dat_i, wb_sel_i);

  always_comb begin
    nxt_ack_ff = wb_cyc_i && wb_stb_i && !ack_ff;
    nxt_rdata_ff = rdata_ff;
    if (rd) begin
      if (wb_adr_i == TFP_OFS_CTRL) begin
        nxt_rdata_ff = {22'h000000, ctrl_ff};
      end else if (wb_adr_i == TFP_OFS_CMPA) begin
        nxt_rdata_ff = {16'h0000, cmp_buf_ff[0]};
      end else if (wb_adr_i == TFP_OFS_CMPB) begin
        nxt_rdata_ff = {16'h0000, cmp_buf_ff[1]};
      end else if (wb_adr_i == TFP_OFS_CAPT) begin
        nxt_rdata_ff = {16'h0000, capt_ff};
      end else if (wb_adr_i == TFP_OFS_CNT) begin
        nxt_rdata_ff = {16'h0000, cnt_ff};
      end else if (wb_adr_i == TFP_OFS_FLAGS) begin
        nxt_rdata_ff = {28'h0000000, flags_ff};
      end else begin
        nxt_rdata_ff = 32'h00000000;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= nxt_ack_ff;
      rdata_ff <= nxt_rdata_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // control, capture and compare registers
  always_comb begin
    nxt_ctrl_ff = ctrl_ff;
    nxt_capt_ff = capt_ff;
    for (int c = 0; c < TFP_NUM_CH; c++) begin
      nxt_cmp_buf_ff[c] = cmp_buf_ff[c];
      if (update || !(fast || phase)) begin
        nxt_cmp_act_ff[c] = cmp_buf_ff[c];
      end else begin
        nxt_cmp_act_ff[c] = cmp_act_ff[c];
      end
    end
    if (wr) begin
      if (wb_adr_i == TFP_OFS_CTRL) begin
        nxt_ctrl_ff = wmerge_ctrl[TFP_CTRL_W-1:0];
      end else if (wb_adr_i == TFP_OFS_CMPA) begin
        nxt_cmp_buf_ff[0] = wmerge_cmp[0][15:0] & fixed_top(mode);
      end else if (wb_adr_i == TFP_OFS_CMPB) begin
        nxt_cmp_buf_ff[1] = wmerge_cmp[1][15:0] & fixed_top(mode);
      end else if (wb_adr_i == TFP_OFS_CAPT) begin
        nxt_capt_ff = wmerge_capt[15:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_ff <= TFP_CTRL_RST;
      capt_ff <= TFP_CNT_RST;
      for (int c = 0; c < TFP_NUM_CH; c++) begin
        cmp_buf_ff[c] <= TFP_CNT_RST;
        cmp_act_ff[c] <= TFP_CNT_RST;
      end
    end else begin
      ctrl_ff <= nxt_ctrl_ff;
      capt_ff <= nxt_capt_ff;
      for (int c = 0; c < TFP_NUM_CH; c++) begin
        cmp_buf_ff[c] <= nxt_cmp_buf_ff[c];
        cmp_act_ff[c] <= nxt_cmp_act_ff[c];
      end
    end
  end

  // counter and direction
  always_comb begin
    nxt_cnt_ff = cnt_ff;
    nxt_dir_ff = dir_ff;
    if (timer_tick_i && fast) begin
      nxt_dir_ff = DIR_UP;
      // single slope, limit plus one ticks
      if (at_top) begin
        nxt_cnt_ff = TFP_FLOOR;
      end else begin
        // missed limit runs on through ceiling
        nxt_cnt_ff = cnt_ff + TFP_ONE;
      end
    end else if (timer_tick_i && phase) begin
      if (dir_ff == DIR_UP) begin
        if (at_top) begin
          nxt_dir_ff = DIR_DOWN;
          nxt_cnt_ff = cnt_ff - TFP_ONE;
        end else begin
          nxt_cnt_ff = cnt_ff + TFP_ONE;
        end
      end else begin
        if (cnt_ff == TFP_FLOOR) begin
          nxt_dir_ff = DIR_UP;
          nxt_cnt_ff = cnt_ff + TFP_ONE;
        end else begin
          nxt_cnt_ff = cnt_ff - TFP_ONE;
        end
      end
    end
    if (wr && wb_adr_i == TFP_OFS_CNT) begin
      nxt_cnt_ff = wmerge_cnt[15:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_ff <= TFP_CNT_RST;
      dir_ff <= DIR_UP;
    end else begin
      cnt_ff <= nxt_cnt_ff;
      dir_ff <= nxt_dir_ff;
    end
  end

  // flags: clear first so that a same cycle event still sets
  always_comb begin
    nxt_flags_ff = flags_ff;
    if (wr && wb_adr_i == TFP_OFS_FLAGS && wb_sel_i[0]) begin
      nxt_flags_ff = flags_ff & ~wb_dat_i[TFP_FLG_W-1:0];
    end
    if (fast_wrap || floor_reach) begin
      nxt_flags_ff[TFP_FLG_OVF] = 1'b1;
    end
    if (update && capt_is_top(mode)) begin
      nxt_flags_ff[TFP_FLG_CAPT] = 1'b1;
    end
    if ((update && cmpa_is_top(mode)) || match[0]) begin
      nxt_flags_ff[TFP_FLG_CMPA] = 1'b1;
    end
    if (match[1]) begin
      nxt_flags_ff[TFP_FLG_CMPB] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_ff <= TFP_FLG_RST;
    end else begin
      flags_ff <= nxt_flags_ff;
    end
  end

  // output units
  generate
    for (genvar c = 0; c < TFP_NUM_CH; c++) begin : g_out
      tfp_out_unit u_out (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(timer_tick_i),
        .fast_i(fast),
        .phase_i(phase),
        .count_up_i(dir_ff == DIR_UP),
        .match_i(match[c]),
        .wrap_i(fast_wrap),
        .cmp_is_top_i(cmp_top[c]),
        .cmp_is_floor_i(cmp_floor[c]),
        .action_i(act_sel[c]),
        .toggle_ok_i((c == 0) && cmpa_is_top(mode)),
        .pin_dir_i(ctrl_ff[TFP_CTRL_DIR_LSB + c]),
        .pin_o(ch_pin[c]),
        .pin_oe_o(ch_oe[c])
      );
    end
  endgenerate

  assign compare_a_output_o = ch_pin[0];
  assign compare_a_output_oe_o = ch_oe[0];
  assign compare_b_output_o = ch_pin[1];
  assign compare_b_output_oe_o = ch_oe[1];
endmodule // tfp_timer16_pwm

//--- verification/tfp_pin_load.sv
module tfp_pin_load (
  // clock and window
  input wire logic ref_clk_i,
  input wire logic clr_i,
  input wire logic run_i,
  // pin from the block
  input wire logic pin_i,
  input wire logic pin_oe_i,
  // seen level and counts
  output logic line_o,
  output logic [15:0] high_cnt_o,
  output logic [15:0] rise_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_ff;
  assign line_o = pin_oe_i ? pin_i : 1'h0;
  always_ff @(posedge ref_clk_i) begin
    prev_ff <= line_o;
    if (clr_i) begin
      high_cnt_o <= 16'h0000;
      rise_cnt_o <= 16'h0000;
    end else if (run_i) begin
      high_cnt_o <= high_cnt_o + {15'h0000, line_o};
      rise_cnt_o <= rise_cnt_o + {15'h0000, line_o & ~prev_ff};
    end
  end
endmodule // tfp_pin_load

//--- verification/tfp_timer16_pwm_sva.sv
module tfp_timer16_pwm_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // tick and bus
  input wire logic timer_tick_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic compare_a_output_o,
  input wire logic compare_a_output_oe_o,
  input wire logic compare_b_output_o,
  input wire logic compare_b_output_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE_WAIT:
    assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o) else $error("ack late");
  AST_ACK_PULSE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_ACK_HAS_REQ:
    assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("ack without request");
  AST_DAT_ON_READ:
    assert property ($changed(wb_dat_o) |-> $past(wb_cyc_i && wb_stb_i && !wb_we_i))
      else $error("read data moved without read");
  AST_A_ON_TICK:
    assert property ($changed(compare_a_output_o) |-> $past(timer_tick_i))
      else $error("pin a moved without tick");
  AST_B_ON_TICK:
    assert property (!timer_tick_i |=> $stable(compare_b_output_o))
      else $error("pin b moved without tick");
  AST_OE_A_WRITE:
    assert property ($changed(compare_a_output_oe_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("enable a moved without write");
  AST_OE_B_WRITE:
    assert property (!(wb_ack_o && wb_we_i) |=> $stable(compare_b_output_oe_o))
      else $error("enable b moved without write");
endmodule // tfp_timer16_pwm_chk

bind tfp_timer16_pwm tfp_timer16_pwm_chk chk_u (.ref_clk_i, .rst_i, .timer_tick_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .compare_a_output_o, .compare_a_output_oe_o,
  .compare_b_output_o, .compare_b_output_oe_o);

//--- verification/tfp_timer16_pwm_test.sv
module tfp_timer16_pwm_test
  import tfp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'h0, rst = 1'h1, tick = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic clr = 1'h1, run = 1'h0, ack, pa, pa_oe, pb, pb_oe;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [15:0] ha, ra, hb;
  logic [3:0] fm [6] = '{TFP_MODE_PC8, TFP_MODE_PC9, TFP_MODE_PC10, TFP_MODE_FP8,
    TFP_MODE_FP9, TFP_MODE_FP10};
  logic [15:0] tops [6] = '{TFP_TOP8, TFP_TOP9, TFP_TOP10, TFP_TOP8, TFP_TOP9, TFP_TOP10};
  int n_fail = 0, cmp_count = 0, seed = 62343;

  initial forever #5 ref_clk = ~ref_clk;

  tfp_timer16_pwm dut_u (.ref_clk_i(ref_clk), .rst_i(rst), .timer_tick_i(tick), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .compare_a_output_o(pa), .compare_a_output_oe_o(pa_oe),
    .compare_b_output_o(pb), .compare_b_output_oe_o(pb_oe));
  tfp_pin_load load_a (.ref_clk_i(ref_clk), .clr_i(clr), .run_i(run), .pin_i(pa),
    .pin_oe_i(pa_oe), .line_o(), .high_cnt_o(ha), .rise_cnt_o(ra));
  tfp_pin_load load_b (.ref_clk_i(ref_clk), .clr_i(clr), .run_i(run), .pin_i(pb),
    .pin_oe_i(pb_oe), .line_o(), .high_cnt_o(hb), .rise_cnt_o());

  task automatic conclude();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge ref_clk); while (ack !== 1'h1);
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'h1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    wb_cycle(1'h0, a, 32'h0);
    chk(what, exp, rdat);
  endtask

  task automatic step_rd(input logic [31:0] exp);
    tick <= 1'h1;
    @(posedge ref_clk);
    tick <= 1'h0;
    rd_chk(TFP_OFS_CNT, exp, "count");
  endtask

  // counts only whole periods, after warm-up; a tick every div cycles
  task automatic run_win(input int warm, input int n, input int div = 1);
    clr <= 1'h1;
    for (int j = 0; j < warm + n; j++) begin
      tick <= (j % div == 0);
      if (j == warm) begin
        clr <= 1'h0;
        run <= 1'h1;
      end
      @(posedge ref_clk);
    end
    run <= 1'h0;
    tick <= 1'h0;
    @(posedge ref_clk);
  endtask

  function automatic int fph(input logic [2:0] c);
    return (c == 3'h7) ? 8 : 7 - int'(c);
  endfunction

  function automatic int pcv(input int k);
    return (k % 12 <= 6) ? k % 12 : 12 - k % 12;
  endfunction

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("mismatch watchdog expected done seen timeout");
    conclude();
  end

  initial begin
    logic [31:0] v;
    logic [2:0] ca;
    logic [2:0] cb;
    repeat (10) @(posedge ref_clk);
    rst <= 1'h0;
    @(posedge ref_clk);
    rd_chk(TFP_OFS_FLAGS, 32'h0, "flags");
    wr(8'h20, 32'hFFFF);
    rd_chk(8'h20, 32'h0, "unmapped");
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(TFP_OFS_CTRL, {28'h0, fm[i]});
      wr(i[0] ? TFP_OFS_CMPA : TFP_OFS_CMPB, v);
      rd_chk(i[0] ? TFP_OFS_CMPA : TFP_OFS_CMPB, v & {16'h0, tops[i]}, "cmp");
    end
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      ca = (k == 0) ? 3'h0 : (k == 1) ? 3'h7 : v[2:0];
      cb = (k == 1) ? 3'h0 : v[5:3];
      wr(TFP_OFS_CTRL, 32'h0);
      wr(TFP_OFS_CAPT, 32'h7);
      wr(TFP_OFS_CMPA, {29'h0, ca});
      wr(TFP_OFS_CMPB, {29'h0, cb});
      wr(TFP_OFS_CTRL, 32'h3BE);
      run_win(32, 64);
      chk("high a", 32'(8 * fph(ca)), 32'(ha));
      chk("high b", 32'(64 - 8 * fph(cb)), 32'(hb));
      chk("rises a", (ca == 3'h7) ? 32'h0 : 32'h8, 32'(ra));
    end
    rd_chk(TFP_OFS_FLAGS, 32'hF, "flags");
    wr(TFP_OFS_FLAGS, 32'hF);
    rd_chk(TFP_OFS_FLAGS, 32'h0, "flags");
    wr(TFP_OFS_CTRL, 32'h1BE);
    chk("oe", 32'h2, {30'h0, pa_oe, pb_oe});
    wr(TFP_OFS_CTRL, 32'h20E);
    chk("oe", 32'h0, {30'h0, pa_oe, pb_oe});
    wr(TFP_OFS_CAPT, 32'h3);
    wr(TFP_OFS_CNT, 32'h5);
    step_rd(32'h6);
    wr(TFP_OFS_CNT, 32'hFFFF);
    step_rd(32'h0);
    wr(TFP_OFS_CTRL, 32'h0);
    wr(TFP_OFS_CMPA, 32'h5);
    wr(TFP_OFS_CNT, 32'h0);
    wr(TFP_OFS_CTRL, 32'hF);
    wr(TFP_OFS_CMPA, 32'h2);
    for (int i = 0; i < 9; i++) step_rd(32'((i < 6) ? (i + 1) % 6 : (i - 5) % 3));
    wr(TFP_OFS_CTRL, 32'h0);
    wr(TFP_OFS_CMPA, 32'h6);
    wr(TFP_OFS_CMPB, 32'h2);
    wr(TFP_OFS_CNT, 32'h0);
    wr(TFP_OFS_FLAGS, 32'hF);
    wr(TFP_OFS_CTRL, 32'h36B);
    for (int k = 1; k < 14; k++) step_rd(32'(pcv(k)));
    rd_chk(TFP_OFS_FLAGS, 32'h7, "flags");
    // limit kept static while phase correct runs
    for (int k = 0; k < 3; k++) begin
      v = $random(seed);
      cb = (k == 0) ? 3'h0 : (k == 1) ? 3'h6 : 3'(v % 32'h7);
      wr(TFP_OFS_CTRL, 32'h0);
      wr(TFP_OFS_CMPB, {29'h0, cb});
      wr(TFP_OFS_CTRL, (k == 2) ? 32'h37B : 32'h36B);
      run_win(24, 96);
      chk("high a", 32'h30, 32'(ha));
      chk("rises a", 32'h4, 32'(ra));
      chk("high b", 32'((k == 2) ? 96 - 16 * cb : 16 * cb), 32'(hb));
    end
    v = $random(seed);
    cb = {1'h0, v[1:0]};
    wr(TFP_OFS_CTRL, 32'h0);
    wr(TFP_OFS_CNT, 32'h0);
    // compares kept at or below the limit
    wr(TFP_OFS_CMPA, 32'h3);
    wr(TFP_OFS_CMPB, {29'h0, cb});
    wr(TFP_OFS_CTRL, 32'h36F);
    run_win(64, 256, 8);
    chk("high a", 32'h80, 32'(ha));
    chk("rises a", 32'h4, 32'(ra));
    chk("high b", 32'(64 * ((cb == 3'h3) ? 4 : 3 - int'(cb))), 32'(hb));
    tick <= 1'h1;
    repeat (5) @(posedge ref_clk);
    rst <= 1'h1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    tick <= 1'h0;
    @(posedge ref_clk);
    rd_chk(TFP_OFS_CNT, 32'h0, "count");
    rd_chk(TFP_OFS_CTRL, 32'h0, "ctrl");
    chk("pins", 32'h0, {30'h0, pa, pb});
    conclude();
  end
endmodule // tfp_timer16_pwm_test
